// [include/ssfr_defines.svh]
// Register offsets, field positions and reset values of the transmit framing block
`ifndef SSFR_DEFINES_SVH
`define SSFR_DEFINES_SVH

`define SSFR_ADDR_CTRL        32'hF0010000
`define SSFR_ADDR_CLKDIV      32'hF0010004
`define SSFR_ADDR_TX_CLK_MODE 32'hF0010018
`define SSFR_ADDR_TX_FRM_MODE 32'hF001001C
`define SSFR_ADDR_RX_HOLDING  32'hF0010020
`define SSFR_ADDR_TX_HOLDING  32'hF0010024
`define SSFR_ADDR_TX_SYNC_HLD 32'hF0010034
`define SSFR_ADDR_STATUS      32'hF0010040
`define SSFR_ADDR_WPROT       32'hF00100E4

`define SSFR_F_CKS      1:0
`define SSFR_F_CKO      4:2
`define SSFR_B_CKI      5
`define SSFR_F_CKG      7:6
`define SSFR_F_START    11:8
`define SSFR_F_START_DELAY   23:16
`define SSFR_F_PERIOD   31:24

`define SSFR_F_WORD_BIT_COUNT   4:0
`define SSFR_B_IDLE_LINE_LEVEL   5
`define SSFR_B_MSB_FIRST_SELECT     7
`define SSFR_F_WORDS_PER_FRAME    11:8
`define SSFR_F_SYNC_PULSE_LENGTH    19:16
`define SSFR_F_SYNC_OUTPUT_SELECT     22:20
`define SSFR_B_SYNC_DATA_ENABLE    23
`define SSFR_B_SYNC_EDGE_SELECT   24
`define SSFR_F_FSLENX   31:28

`define SSFR_F_CLKDIV   11:0
`define SSFR_B_TXEN     0
`define SSFR_B_WRITE_PROTECT_ENABLE     0

`define SSFR_SR_TXRDY   0
`define SSFR_SR_TXEMPTY 1
`define SSFR_SR_RX_READY_FLAG   4
`define SSFR_SR_RX_OVERRUN_FLAG   5
`define SSFR_SR_TX_SYNC_EVENT   10
`define SSFR_SR_TXEN    16

`define SSFR_RESET_WORD 32'h00000000
`define SSFR_RESET_HALF 16'h0000
`define SSFR_RESET_DIV  12'h000

`endif

// [include/ssfr_pkg.sv]
// Types shared by the transmit framing block
package ssfr_pkg;
   typedef enum logic [1:0] {
      SSFR_IDLE,
      SSFR_LEAD,
      SSFR_DATA
   } ssfr_state_t;
endpackage : ssfr_pkg

// [hdl/ssfr_sync.sv]
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module ssfr_sync (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] async_in,
   output logic      [2:0] sync_out
);
   logic [2:0] stage1;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1   <= 3'h0;
         sync_out <= 3'h0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : ssfr_sync

// [hdl/ssfr_top.sv]
// Transmit clock and frame logic with receive holding register, Avalon-MM slave
`timescale 1ns/1ps
`include "ssfr_defines.svh"

module ssfr_top (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        tx_clock_pin_in,
   output logic             tx_clock_pin_out,
   output logic             tx_clock_pin_oe,
   input  wire logic        tx_sync_pin_in,
   output logic             tx_sync_pin_out,
   output logic             tx_sync_pin_oe,
   output logic             tx_data_pin_out,
   output logic             tx_data_pin_oe,
   input  wire logic        rx_clock_pin_in,
   input  wire logic        rx_start,
   input  wire logic [31:0] received_word,
   input  wire logic        rx_word_valid
);
   logic [31:0]          tx_clock_mode;
   logic [31:0]          tx_frame_mode;
   logic [31:0]          rx_holding;
   logic [31:0]          tx_holding;
   logic [15:0]          tx_sync_holding;
   logic [11:0]          clk_div;
   logic                 tx_enable;
   logic                 write_protect_enable;
   logic                 tx_holding_full;
   logic                 rx_ready_flag;
   logic                 rx_overrun_flag;
   logic                 tx_sync_event;
   logic [2:0]           pins_sync;
   logic                 s_tk;
   logic                 s_tf;
   logic                 s_rk;
   logic [11:0]          div_cnt;
   logic                 div_clk;
   logic                 sel_clk;
   logic                 sel_prev;
   logic                 gate_ok;
   logic                 shift_en;
   logic                 samp_en;
   logic                 tf_smp;
   logic                 tf_old;
   logic                 rx_start_pend;
   logic [8:0]           per_cnt;
   logic                 per_tick;
   logic                 start_hit;
   logic                 frame_end;
   logic                 frame_go;
   ssfr_pkg::ssfr_state_t state;
   ssfr_pkg::ssfr_state_t next_state;
   logic [7:0]           dly_left;
   logic [7:0]           next_dly_left;
   logic [4:0]           bit_cnt;
   logic [4:0]           next_bit_cnt;
   logic [3:0]           word_left;
   logic [3:0]           next_word_left;
   logic                 next_load;
   logic [31:0]          word;
   logic [8:0]           sync_left;
   logic [8:0]           next_sync_left;
   logic [8:0]           fs_len;
   logic [8:0]           sync_idx;
   logic [4:0]           sync_last;
   logic                 next_td;
   logic                 next_tf;
   logic                 tf_toggle;
   logic                 tf_seen;
   logic                 tf_seen_prev;
   logic                 bus_req;
   logic                 bus_take;
   logic                 wr_take;
   logic                 rd_take;
   logic                 thr_write;
   logic                 rhr_read;
   logic                 sr_read;

   // Picks one bit of a word in the configured order
   function automatic logic bit_of(input logic [31:0] w, input logic [4:0] idx,
                                   input logic msb_first_select, input logic [4:0] last);
      logic [4:0] pos;
      pos = msb_first_select ? 5'(last - idx) : idx;
      return w[pos];
   endfunction : bit_of

   // Merges write data under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   ssfr_sync u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in ({rx_clock_pin_in, tx_sync_pin_in, tx_clock_pin_in}),
      .sync_out (pins_sync)
   );

   assign s_tk = pins_sync[0];
   assign s_tf = pins_sync[1];
   assign s_rk = pins_sync[2];

   // Bus handshake: one wait cycle, then the access is taken
   assign bus_req   = avs_read | avs_write;
   assign bus_take  = bus_req & ~avs_waitrequest;
   assign wr_take   = bus_take & avs_write;
   assign rd_take   = bus_take & avs_read;
   assign thr_write = wr_take & (avs_address == `SSFR_ADDR_TX_HOLDING);
   assign rhr_read  = rd_take & (avs_address == `SSFR_ADDR_RX_HOLDING);
   assign sr_read   = rd_take & (avs_address == `SSFR_ADDR_STATUS);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
         avs_waitrequest <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= `SSFR_RESET_WORD;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= `SSFR_RESET_WORD;
         unique case (avs_address)
            `SSFR_ADDR_CTRL:        avs_readdata[`SSFR_B_TXEN] <= tx_enable;
            `SSFR_ADDR_CLKDIV:      avs_readdata[`SSFR_F_CLKDIV] <= clk_div;
            `SSFR_ADDR_TX_CLK_MODE: avs_readdata <= tx_clock_mode;
            `SSFR_ADDR_TX_FRM_MODE: avs_readdata <= tx_frame_mode;
            `SSFR_ADDR_RX_HOLDING:  avs_readdata <= rx_holding;
            `SSFR_ADDR_TX_SYNC_HLD: avs_readdata[15:0] <= tx_sync_holding;
            `SSFR_ADDR_WPROT:       avs_readdata[`SSFR_B_WRITE_PROTECT_ENABLE] <= write_protect_enable;
            `SSFR_ADDR_STATUS: begin
               avs_readdata[`SSFR_SR_TXRDY]   <= ~tx_holding_full;
               avs_readdata[`SSFR_SR_TXEMPTY] <= ~tx_holding_full & (state == ssfr_pkg::SSFR_IDLE);
               avs_readdata[`SSFR_SR_RX_READY_FLAG]   <= rx_ready_flag;
               avs_readdata[`SSFR_SR_RX_OVERRUN_FLAG]   <= rx_overrun_flag;
               avs_readdata[`SSFR_SR_TX_SYNC_EVENT]   <= tx_sync_event;
               avs_readdata[`SSFR_SR_TXEN]    <= tx_enable;
            end
            default:                avs_readdata <= `SSFR_RESET_WORD;
         endcase
      end
   end

   // Configuration writes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_clock_mode        <= `SSFR_RESET_WORD;
         tx_frame_mode        <= `SSFR_RESET_WORD;
         tx_sync_holding      <= `SSFR_RESET_HALF;
         clk_div              <= `SSFR_RESET_DIV;
         tx_enable            <= 1'b0;
         write_protect_enable <= 1'b0;
      end else if (wr_take) begin
         if (avs_address == `SSFR_ADDR_TX_CLK_MODE && !write_protect_enable) begin
            tx_clock_mode <= merge(tx_clock_mode, avs_writedata, avs_byteenable);
         end
         if (avs_address == `SSFR_ADDR_TX_FRM_MODE && !write_protect_enable) begin
            tx_frame_mode <= merge(tx_frame_mode, avs_writedata, avs_byteenable);
         end
         if (avs_address == `SSFR_ADDR_TX_SYNC_HLD) begin
            tx_sync_holding <= 16'(merge({16'h0000, tx_sync_holding}, avs_writedata, avs_byteenable));
         end
         if (avs_address == `SSFR_ADDR_CLKDIV) begin
            clk_div <= 12'(merge({20'h00000, clk_div}, avs_writedata, avs_byteenable));
         end
         if (avs_address == `SSFR_ADDR_CTRL && avs_byteenable[0]) begin
            tx_enable <= avs_writedata[`SSFR_B_TXEN];
         end
         if (avs_address == `SSFR_ADDR_WPROT && avs_byteenable[0]) begin
            write_protect_enable <= avs_writedata[`SSFR_B_WRITE_PROTECT_ENABLE];
         end
      end
   end

   // Transmit holding register; a bus write wins over a same-cycle load
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_holding      <= `SSFR_RESET_WORD;
         tx_holding_full <= 1'b0;
      end else if (thr_write) begin
         tx_holding      <= merge(tx_holding, avs_writedata, avs_byteenable);
         tx_holding_full <= 1'b1;
      end else if (shift_en && next_load) begin
         tx_holding_full <= 1'b0;
      end
   end

   // Receive holding register and its flags
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_holding      <= `SSFR_RESET_WORD;
         rx_ready_flag   <= 1'b0;
         rx_overrun_flag <= 1'b0;
      end else begin
         if (rx_word_valid) begin
            rx_holding <= received_word;
         end
         if (rx_word_valid) begin
            rx_ready_flag <= 1'b1;
         end else if (rhr_read) begin
            rx_ready_flag <= 1'b0;
         end
         if (rx_word_valid && rx_ready_flag && !rhr_read) begin
            rx_overrun_flag <= 1'b1;
         end else if (sr_read) begin
            rx_overrun_flag <= 1'b0;
         end
      end
   end

   // Divided clock
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= 12'h000;
         div_clk <= 1'b0;
      end else if (clk_div == 12'h000) begin
         div_cnt <= 12'h000;
      end else if (div_cnt >= 12'(clk_div - 12'h001)) begin
         div_cnt <= 12'h000;
         div_clk <= ~div_clk;
      end else begin
         div_cnt <= 12'(div_cnt + 12'h001);
      end
   end

   always_comb begin
      unique case (tx_clock_mode[`SSFR_F_CKS])
         2'h1:    sel_clk = s_rk;
         2'h2:    sel_clk = s_tk;
         default: sel_clk = div_clk;
      endcase
   end

   always_comb begin
      unique case (tx_clock_mode[`SSFR_F_CKG])
         2'h1:    gate_ok = ~s_tf;
         2'h2:    gate_ok = s_tf;
         default: gate_ok = 1'b1;
      endcase
   end

   assign shift_en = gate_ok & (tx_clock_mode[`SSFR_B_CKI] ? (sel_clk & ~sel_prev) : (~sel_clk & sel_prev));
   assign samp_en  = gate_ok & (tx_clock_mode[`SSFR_B_CKI] ? (~sel_clk & sel_prev) : (sel_clk & ~sel_prev));

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_prev <= 1'b0;
         tf_smp   <= 1'b0;
         tf_old   <= 1'b0;
      end else begin
         sel_prev <= sel_clk;
         if (samp_en) begin
            tf_smp <= s_tf;
            tf_old <= tf_smp;
         end
      end
   end

   // Receiver start is held until the next shift edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_start_pend <= 1'b0;
      end else if (rx_start) begin
         rx_start_pend <= 1'b1;
      end else if (shift_en) begin
         rx_start_pend <= 1'b0;
      end
   end

   assign per_tick = (tx_clock_mode[`SSFR_F_PERIOD] != 8'h00) && (per_cnt == {tx_clock_mode[`SSFR_F_PERIOD], 1'b1});

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         per_cnt <= 9'h000;
      end else if (tx_clock_mode[`SSFR_F_PERIOD] == 8'h00) begin
         per_cnt <= 9'h000;
      end else if (shift_en) begin
         per_cnt <= per_tick ? 9'h000 : 9'(per_cnt + 9'h001);
      end
   end

   always_comb begin
      unique case (tx_clock_mode[`SSFR_F_START])
         4'h0:    start_hit = tx_holding_full;
         4'h1:    start_hit = rx_start_pend;
         4'h2:    start_hit = ~tf_smp;
         4'h3:    start_hit = tf_smp;
         4'h4:    start_hit = tf_old & ~tf_smp;
         4'h5:    start_hit = ~tf_old & tf_smp;
         4'h6:    start_hit = tf_old ^ tf_smp;
         4'h7:    start_hit = tf_old ^ tf_smp;
         default: start_hit = 1'b0;
      endcase
      if (tx_clock_mode[`SSFR_F_PERIOD] != 8'h00) begin
         start_hit = per_tick;
      end
   end

   assign fs_len    = 9'(tx_frame_mode[`SSFR_F_SYNC_PULSE_LENGTH]) + {1'b0, tx_frame_mode[`SSFR_F_FSLENX], 4'h0} + 9'h001;
   assign sync_last = (fs_len[8:4] != 5'h00) ? 5'h0F : 5'(fs_len - 9'h001);
   // frame end after the last bit of the last word
   assign frame_end = (state == ssfr_pkg::SSFR_DATA) && (bit_cnt == tx_frame_mode[`SSFR_F_WORD_BIT_COUNT])
                      && (word_left == 4'h0);
   assign frame_go  = tx_enable & start_hit & ((state == ssfr_pkg::SSFR_IDLE) | frame_end);

   always_comb begin
      next_state     = state;
      next_dly_left  = dly_left;
      next_bit_cnt   = bit_cnt;
      next_word_left = word_left;
      next_load      = 1'b0;
      next_sync_left = (sync_left != 9'h000) ? 9'(sync_left - 9'h001) : 9'h000;
      if (frame_go) begin
         next_sync_left = fs_len;
         if (tx_clock_mode[`SSFR_F_START_DELAY] == 8'h00) begin
            next_state     = ssfr_pkg::SSFR_DATA;
            next_load      = 1'b1;
            next_bit_cnt   = 5'h00;
            next_word_left = tx_frame_mode[`SSFR_F_WORDS_PER_FRAME];
         end else begin
            next_state    = ssfr_pkg::SSFR_LEAD;
            next_dly_left = tx_clock_mode[`SSFR_F_START_DELAY];
         end
      end else begin
         unique case (state)
            ssfr_pkg::SSFR_IDLE: begin
               next_state = ssfr_pkg::SSFR_IDLE;
            end
            ssfr_pkg::SSFR_LEAD: begin
               if (dly_left == 8'h01) begin
                  next_state     = ssfr_pkg::SSFR_DATA;
                  next_load      = 1'b1;
                  next_bit_cnt   = 5'h00;
                  next_word_left = tx_frame_mode[`SSFR_F_WORDS_PER_FRAME];
               end else begin
                  next_dly_left = 8'(dly_left - 8'h01);
               end
            end
            ssfr_pkg::SSFR_DATA: begin
               if (bit_cnt != tx_frame_mode[`SSFR_F_WORD_BIT_COUNT]) begin
                  next_bit_cnt = 5'(bit_cnt + 5'h01);
               end else if (word_left != 4'h0) begin
                  next_load      = 1'b1;
                  next_bit_cnt   = 5'h00;
                  next_word_left = 4'(word_left - 4'h1);
               end else begin
                  next_state = ssfr_pkg::SSFR_IDLE;
               end
            end
         endcase
      end
      sync_idx = 9'(fs_len - next_sync_left);
      // data line priority: data, sync data, idle level
      if (next_state == ssfr_pkg::SSFR_DATA) begin
         next_td = bit_of(next_load ? tx_holding : word, next_bit_cnt, tx_frame_mode[`SSFR_B_MSB_FIRST_SELECT],
                          tx_frame_mode[`SSFR_F_WORD_BIT_COUNT]);
      end else if (next_sync_left != 9'h000 && tx_frame_mode[`SSFR_B_SYNC_DATA_ENABLE] && sync_idx[8:4] == 5'h00) begin
         next_td = bit_of({16'h0000, tx_sync_holding}, sync_idx[4:0], tx_frame_mode[`SSFR_B_MSB_FIRST_SELECT], sync_last);
      end else begin
         next_td = tx_frame_mode[`SSFR_B_IDLE_LINE_LEVEL];
      end
      unique case (tx_frame_mode[`SSFR_F_SYNC_OUTPUT_SELECT])
         3'h1:    next_tf = (next_sync_left == 9'h000);
         3'h2:    next_tf = (next_sync_left != 9'h000);
         3'h3:    next_tf = (next_state == ssfr_pkg::SSFR_IDLE);
         3'h4:    next_tf = (next_state != ssfr_pkg::SSFR_IDLE);
         3'h5:    next_tf = tf_toggle ^ frame_go;
         default: next_tf = 1'b0;
      endcase
   end

   // Transmit engine, advanced on shift edges
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state           <= ssfr_pkg::SSFR_IDLE;
         dly_left        <= 8'h00;
         bit_cnt         <= 5'h00;
         word_left       <= 4'h0;
         word            <= `SSFR_RESET_WORD;
         sync_left       <= 9'h000;
         tf_toggle       <= 1'b0;
         tx_data_pin_out <= 1'b0;
         tx_sync_pin_out <= 1'b0;
      end else if (shift_en) begin
         state           <= next_state;
         dly_left        <= next_dly_left;
         bit_cnt         <= next_bit_cnt;
         word_left       <= next_word_left;
         sync_left       <= next_sync_left;
         tf_toggle       <= tf_toggle ^ frame_go;
         tx_data_pin_out <= next_td;
         tx_sync_pin_out <= next_tf;
         if (next_load) begin
            word <= tx_holding;
         end
      end
   end

   // Pin directions and driven clock
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_clock_pin_out <= 1'b0;
         tx_clock_pin_oe  <= 1'b0;
         tx_sync_pin_oe   <= 1'b0;
         tx_data_pin_oe   <= 1'b0;
      end else begin
         tx_clock_pin_oe  <= (tx_clock_mode[`SSFR_F_CKO] == 3'h1) | (tx_clock_mode[`SSFR_F_CKO] == 3'h2);
         tx_clock_pin_out <= sel_clk & ((tx_clock_mode[`SSFR_F_CKO] != 3'h2) | (state != ssfr_pkg::SSFR_IDLE));
         tx_sync_pin_oe   <= (tx_frame_mode[`SSFR_F_SYNC_OUTPUT_SELECT] != 3'h0);
         tx_data_pin_oe   <= 1'b1;
      end
   end

   // sync edge flag, set wins over read clear
   assign tf_seen = tx_sync_pin_oe ? tx_sync_pin_out : s_tf;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tf_seen_prev  <= 1'b0;
         tx_sync_event <= 1'b0;
      end else begin
         tf_seen_prev <= tf_seen;
         if (tx_frame_mode[`SSFR_B_SYNC_EDGE_SELECT] ? (tf_seen_prev & ~tf_seen) : (~tf_seen_prev & tf_seen)) begin
            tx_sync_event <= 1'b1;
         end else if (sr_read) begin
            tx_sync_event <= 1'b0;
         end
      end
   end
endmodule : ssfr_top

// [verif/ssfr_chk.sv]
// Port assertions for the transmit framing block
`timescale 1ns/1ps
`include "ssfr_defines.svh"
module ssfr_chk (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [31:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        tx_clock_pin_oe,
   input wire logic        tx_sync_pin_oe,
   input wire logic [31:0] received_word,
   input wire logic        rx_word_valid
);
   logic [31:0] cm, fm, rxw;
   logic        wp, rdy, ovr, wr, rd;
   assign wr = avs_write && !avs_waitrequest;
   assign rd = avs_read && !avs_waitrequest;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {cm, fm, rxw, wp, rdy, ovr} <= '0;
      end else begin
         if (wr && avs_address == `SSFR_ADDR_WPROT) wp <= avs_writedata[0];
         if (wr && !wp && avs_address == `SSFR_ADDR_TX_CLK_MODE) cm <= avs_writedata;
         if (wr && !wp && avs_address == `SSFR_ADDR_TX_FRM_MODE) fm <= avs_writedata;
         if (rx_word_valid) rxw <= received_word;
         rdy <= rx_word_valid || (rdy && !(rd && avs_address == `SSFR_ADDR_RX_HOLDING));
         ovr <= (rx_word_valid && rdy && !(rd && avs_address == `SSFR_ADDR_RX_HOLDING))
                || (ovr && !(rd && avs_address == `SSFR_ADDR_STATUS));
      end
   end
   sequence s_rd(a);
      rd && avs_address == a;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus not answered");
   AST_WAIT_ONE: assert property (wr || rd |-> s_ack)
      else $error("wait low too long");
   AST_RD_MODE: assert property (s_rd(`SSFR_ADDR_TX_CLK_MODE) |-> avs_readdata == cm)
      else $error("clock mode readback");
   AST_RD_RXH: assert property (s_rd(`SSFR_ADDR_RX_HOLDING) |-> avs_readdata == $past(rxw))
      else $error("receive word");
   AST_RD_STAT: assert property (s_rd(`SSFR_ADDR_STATUS) |-> avs_readdata[5:4] == $past({ovr, rdy}))
      else $error("receive flags");
   AST_CKO_OFF: assert property ((cm[4:2] == 3'h0)[*2] |-> !tx_clock_pin_oe)
      else $error("clock pin driven");
   AST_CKO_ON: assert property ((cm[4:2] == 3'h1)[*2] |-> tx_clock_pin_oe)
      else $error("clock pin not driven");
   AST_FS_ON: assert property ((fm[22:20] == 3'h2)[*2] |-> tx_sync_pin_oe)
      else $error("sync pin not driven");
endmodule : ssfr_chk
bind ssfr_top ssfr_chk i_ssfr_chk (.*);

// [verif/ssfr_codec.sv]
// Codec model sampling the serial transmit stream
`timescale 1ns/1ps
module ssfr_codec (
   input wire logic        sys_clk,
   input wire logic        sck,
   input wire logic        fs,
   input wire logic        sd,
   output logic     [15:0] word = 16'h0,
   output logic     [7:0]  bits = 8'h0
);
   logic sck_d = 1'h0;
   always @(posedge sys_clk) begin
      sck_d <= sck;
      if (sck && !sck_d && fs) begin
         bits <= 8'h1;
         word <= {15'h0, sd};
      end else if (sck && !sck_d && bits != 8'h0) begin
         bits <= bits + 8'h1;
         word <= {word[14:0], sd};
      end
   end
endmodule : ssfr_codec

// [verif/tb_sync_serial_tx_framing.sv]
// Self-checking bench for the transmit framing block
`timescale 1ns/1ps
`include "ssfr_defines.svh"
module tb_sync_serial_tx_framing;
   logic        sys_clk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, rx_word_valid = 1'h0;
   logic [31:0] avs_address = '0, avs_writedata = '0, received_word = '0, avs_readdata, q;
   logic        avs_waitrequest, tx_clock_pin_out, tx_clock_pin_oe, tx_sync_pin_out, tx_sync_pin_oe;
   logic        tx_data_pin_out;
   logic [15:0] word;
   logic [7:0]  bits;
   int          failures = 0, checks_done = 0;
   always #20 sys_clk = ~sys_clk;
   ssfr_top i_ssfr_top (.*, .avs_byteenable(4'hF), .tx_clock_pin_in(tx_clock_pin_out & tx_clock_pin_oe),
      .tx_sync_pin_in(tx_sync_pin_out & tx_sync_pin_oe), .tx_data_pin_oe(), .rx_clock_pin_in(1'h0), .rx_start(1'h0));
   ssfr_codec i_ssfr_codec (.sys_clk(sys_clk), .sck(tx_clock_pin_out & tx_clock_pin_oe),
      .fs(tx_sync_pin_out & tx_sync_pin_oe), .sd(tx_data_pin_out), .word(word), .bits(bits));
   task automatic fail(input string m);
      failures++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks_done++;
      if (g !== e) fail(m);
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'h0 && ++n < 50);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (n >= 50) fail("bus hang");
   endtask : bus
   task automatic wait_bits(input logic [7:0] b);
      int n;
      n = 0;
      do @(negedge sys_clk); while (bits !== b && ++n < 3000);
      if (n >= 3000) fail("no frame");
   endtask : wait_bits
   task automatic load(input logic [31:0] w);
      @(posedge sys_clk);
      received_word <= w;
      rx_word_valid <= 1'h1;
      @(posedge sys_clk);
      rx_word_valid <= 1'h0;
   endtask : load
   task automatic t_regs;
      bus(1'h1, `SSFR_ADDR_TX_CLK_MODE, 32'h4);
      bus(1'h1, `SSFR_ADDR_WPROT, 32'h1);
      bus(1'h1, `SSFR_ADDR_TX_CLK_MODE, 32'h8);
      bus(1'h0, `SSFR_ADDR_TX_CLK_MODE, 32'h0);
      chk(q, 32'h4, "protected write");
      bus(1'h1, `SSFR_ADDR_WPROT, 32'h0);
      bus(1'h0, 32'hF0010100, 32'h0);
      chk(q, 32'h0, "unmapped read");
      $display("regs done");
   endtask : t_regs
   task automatic t_rx;
      load(32'h12345);
      bus(1'h0, `SSFR_ADDR_STATUS, 32'h0);
      chk(q & 32'h30, 32'h10, "ready");
      bus(1'h0, `SSFR_ADDR_RX_HOLDING, 32'h0);
      chk(q, 32'h12345, "word");
      bus(1'h0, `SSFR_ADDR_STATUS, 32'h0);
      chk(q & 32'h30, 32'h0, "ready clear");
      load(32'hA1);
      load(32'hA2);
      bus(1'h0, `SSFR_ADDR_STATUS, 32'h0);
      chk(q & 32'h30, 32'h30, "overrun");
      bus(1'h0, `SSFR_ADDR_RX_HOLDING, 32'h0);
      chk(q, 32'hA2, "last word");
      $display("rx done");
   endtask : t_rx
   task automatic t_tx;
      bus(1'h1, `SSFR_ADDR_CLKDIV, 32'h8);
      bus(1'h1, `SSFR_ADDR_TX_FRM_MODE, 32'h2000A7);
      bus(1'h1, `SSFR_ADDR_CTRL, 32'h1);
      bus(1'h1, `SSFR_ADDR_TX_HOLDING, 32'h1E);
      wait_bits(8'h8);
      chk({16'h0, word & 16'hFF}, 32'h1E, "msb first");
      wait_bits(8'h9);
      chk({31'h0, word[0]}, 32'h1, "idle level");
      bus(1'h0, `SSFR_ADDR_STATUS, 32'h0);
      chk(q & 32'h403, 32'h403, "sync flag");
      bus(1'h0, `SSFR_ADDR_STATUS, 32'h0);
      chk(q & 32'h400, 32'h0, "sync flag clear");
      bus(1'h1, `SSFR_ADDR_TX_FRM_MODE, 32'h200027);
      bus(1'h1, `SSFR_ADDR_TX_HOLDING, 32'h1E);
      wait_bits(8'h8);
      chk({16'h0, word & 16'hFF}, 32'h78, "lsb first");
      $display("tx done");
   endtask : t_tx
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'h0;
      t_regs();
      t_rx();
      t_tx();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail("timeout");
      print_verdict();
   end
endmodule : tb_sync_serial_tx_framing
